// File: hw/close_fault_window_timer.sv
// close-onto-fault qualifier timers for automatic and manual breaker closing
`timescale 1ns/1ns

module close_fault_window_timer
  import cfw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = cfw_pkg::MS_TICK_CYCLES
)
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        line_deenergized_in,
  input  wire logic                        breaker_close_cmd_in,
  input  wire logic [cfw_pkg::DELAY_W-1:0] dropoff_delay_setting,
  input  wire logic                        dropoff_delay_load,
  output logic                             auto_close_fault_window_out,
  output logic                             manual_close_fault_window_out,
  output logic [cfw_pkg::DELAY_W-1:0]      dropoff_delay_ff
);
  import cfw_pkg::*;

  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  // millisecond time base
  logic [TICK_CNT_W-1:0] tick_cnt_ff;
  logic                  ms_tick_ff;

  wire logic tick_wrap = (tick_cnt_ff == TICK_LAST);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_ff <= '0;
      ms_tick_ff  <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? '0 : tick_cnt_ff + TICK_CNT_W'(1);
      ms_tick_ff  <= tick_wrap;
    end
  end

  // drop-off setting, clamped into its legal range on load
  wire logic                clamp_low  = dropoff_delay_setting < DROPOFF_MIN_MS;
  wire logic                clamp_high = dropoff_delay_setting > DROPOFF_MAX_MS;
  wire logic [DELAY_W-1:0]  delay_clamped =
    clamp_low  ? DROPOFF_MIN_MS :
    clamp_high ? DROPOFF_MAX_MS : dropoff_delay_setting;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dropoff_delay_ff <= DROPOFF_RESET_MS;
    end else if (dropoff_delay_load) begin
      dropoff_delay_ff <= delay_clamped;
    end
  end

  // pick-up of the automatic window: counts whole ms ticks of dead line
  logic [7:0] pickup_cnt_ff;
  logic       pickup_done_ff;

  wire logic pickup_full = (pickup_cnt_ff == PICKUP_TICKS);
  wire logic pickup_step = line_deenergized_in && ms_tick_ff && !pickup_full;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pickup_cnt_ff  <= '0;
      pickup_done_ff <= 1'b0;
    end else begin
      // any gap in the dead-line level restarts the pick-up
      if (!line_deenergized_in) begin
        pickup_cnt_ff <= '0;
      end else if (pickup_step) begin
        pickup_cnt_ff <= pickup_cnt_ff + 8'h01;
      end
      pickup_done_ff <= line_deenergized_in && pickup_full;
    end
  end

  // two independent stretchers sharing the one delay register
  window_pair_t windows;

  dropoff_stretcher u_auto_stretch (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ms_tick  (ms_tick_ff),
    .src      (pickup_done_ff),
    .delay_ms (dropoff_delay_ff),
    .held_ff  (windows.auto_win)
  );

  dropoff_stretcher u_manual_stretch (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .ms_tick  (ms_tick_ff),
    .src      (breaker_close_cmd_in),
    .delay_ms (dropoff_delay_ff),
    .held_ff  (windows.manual_win)
  );

  // outputs are the stretchers' own flops, kept apart
  assign auto_close_fault_window_out   = windows.auto_win;
  assign manual_close_fault_window_out = windows.manual_win;

  // the first partial ms tick costs at most 1 ms, well inside the tolerance

  a_pickup_full_count: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(auto_close_fault_window_out) |-> $past(pickup_cnt_ff, 2) == PICKUP_TICKS)
    else $error("automatic window rose before the full pick-up count");

  a_pickup_needs_line: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(pickup_done_ff) |-> $past(line_deenergized_in))
    else $error("pick-up completed without dead line");

  a_pickup_resets: assert property (
    @(posedge sys_clk) disable iff (reset)
    !line_deenergized_in |=> pickup_cnt_ff == 8'h00 && !pickup_done_ff)
    else $error("pick-up count survived a live line");

  a_auto_holds_on: assert property (
    @(posedge sys_clk) disable iff (reset)
    ($fell(line_deenergized_in) && auto_close_fault_window_out)
      |=> auto_close_fault_window_out [*3])
    else $error("automatic window dropped at once on voltage return");

  a_manual_follows: assert property (
    @(posedge sys_clk) disable iff (reset)
    breaker_close_cmd_in |=> manual_close_fault_window_out)
    else $error("manual window not raised by close command");

  a_manual_stretch: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(breaker_close_cmd_in) |-> ##1 manual_close_fault_window_out [*3])
    else $error("manual window not stretched after close command fell");

  a_delay_range: assert property (
    @(posedge sys_clk) disable iff (reset)
    dropoff_delay_ff >= DROPOFF_MIN_MS && dropoff_delay_ff <= DROPOFF_MAX_MS)
    else $error("drop-off delay outside its legal range");

  a_tick_spacing: assert property (
    @(posedge sys_clk) disable iff (reset)
    ms_tick_ff |-> $past(tick_cnt_ff) == TICK_LAST && tick_cnt_ff == '0)
    else $error("ms tick not spaced by the full period");

  a_auto_only_line: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!auto_close_fault_window_out && !line_deenergized_in && !$past(line_deenergized_in))
      |=> !auto_close_fault_window_out)
    else $error("automatic window rose without dead-line status");

  a_windows_apart: assert property (
    @(posedge sys_clk) disable iff (reset)
    (breaker_close_cmd_in && !manual_close_fault_window_out && !pickup_done_ff
      && !auto_close_fault_window_out) |=> !auto_close_fault_window_out)
    else $error("manual close leaked into the automatic window");

  a_delay_load_takes: assert property (
    @(posedge sys_clk) disable iff (reset)
    (dropoff_delay_load && !clamp_low && !clamp_high)
      |=> dropoff_delay_ff == $past(dropoff_delay_setting))
    else $error("in-range drop-off setting not taken on load");

  a_delay_stays_put: assert property (
    @(posedge sys_clk) disable iff (reset)
    !dropoff_delay_load |=> $stable(dropoff_delay_ff))
    else $error("drop-off delay changed without a load");

  a_clamp_to_min: assert property (
    @(posedge sys_clk) disable iff (reset)
    (dropoff_delay_load && dropoff_delay_setting < DROPOFF_MIN_MS)
      |=> dropoff_delay_ff == DROPOFF_MIN_MS)
    else $error("short drop-off setting not raised to the minimum");

  a_clamp_to_max: assert property (
    @(posedge sys_clk) disable iff (reset)
    (dropoff_delay_load && dropoff_delay_setting > DROPOFF_MAX_MS)
      |=> dropoff_delay_ff == DROPOFF_MAX_MS)
    else $error("long drop-off setting not cut to the maximum");

  a_pickup_count_cap: assert property (
    @(posedge sys_clk) disable iff (reset)
    pickup_cnt_ff <= PICKUP_TICKS)
    else $error("pick-up count ran past its end");

  a_pickup_not_early: assert property (
    @(posedge sys_clk) disable iff (reset)
    (pickup_cnt_ff != PICKUP_TICKS) |=> !pickup_done_ff)
    else $error("pick-up completed before the full count");

  a_pickup_step_one: assert property (
    @(posedge sys_clk) disable iff (reset)
    pickup_step |=> pickup_cnt_ff == $past(pickup_cnt_ff) + 8'h01)
    else $error("pick-up count did not advance on a tick");

  a_auto_follows_done: assert property (
    @(posedge sys_clk) disable iff (reset)
    pickup_done_ff |=> auto_close_fault_window_out)
    else $error("automatic window low while pick-up complete");

  a_auto_stays_idle: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!pickup_done_ff && !auto_close_fault_window_out) |=> !auto_close_fault_window_out)
    else $error("automatic window rose without a completed pick-up");

  a_manual_stays_idle: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!breaker_close_cmd_in && !manual_close_fault_window_out)
      |=> !manual_close_fault_window_out)
    else $error("manual window rose without a close command");

  a_tick_single: assert property (
    @(posedge sys_clk) disable iff (reset)
    ms_tick_ff |=> !ms_tick_ff)
    else $error("ms tick lasted more than one cycle");

  a_tick_count_cap: assert property (
    @(posedge sys_clk) disable iff (reset)
    tick_cnt_ff <= TICK_LAST)
    else $error("tick counter ran past its last count");

endmodule // close_fault_window_timer

// File: hw/cfw_pkg.sv
// shared constants and types for the close-onto-fault window timer
package cfw_pkg;

  // clock and millisecond tick
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned MS_PERIOD_NS   = 1_000_000;
  localparam int unsigned MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W     = 15;

  // pick-up delay of the automatic window, in ms, and its count in ms ticks
  localparam int unsigned PICKUP_DELAY_MS  = 200;
  localparam logic [7:0]  PICKUP_TICKS     = 8'(PICKUP_DELAY_MS);

  // drop-off delay setting, in ms, one tick per step
  localparam int unsigned DELAY_W          = 14;
  localparam logic [13:0] DROPOFF_MIN_MS   = 14'h0064;
  localparam logic [13:0] DROPOFF_MAX_MS   = 14'h2710;
  localparam logic [13:0] DROPOFF_RESET_MS = 14'h03e8;
  localparam logic [13:0] DELAY_STEP       = 14'h0001;

  // drop-off stretcher states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_HOLD
  } stretch_state_t;

  // the two qualifiers, always carried as separate bits
  typedef struct packed {
    logic auto_win;
    logic manual_win;
  } window_pair_t;

endpackage

// File: hw/dropoff_stretcher.sv
// stretches the fall of a level by a drop-off delay counted in ms ticks
`timescale 1ns/1ns
module dropoff_stretcher
  import cfw_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic                        ms_tick,
  input  wire logic                        src,
  input  wire logic [cfw_pkg::DELAY_W-1:0] delay_ms,
  output logic                             held_ff
);
  import cfw_pkg::*;

  stretch_state_t      state_ff;
  stretch_state_t      nxt_state;
  logic [DELAY_W-1:0]  elapsed_ff;
  logic [DELAY_W-1:0]  nxt_elapsed;

  // >= so a setting cut below the elapsed count ends the hold, no wrap of the counter
  wire logic delay_done = ms_tick && (elapsed_ff >= delay_ms - DELAY_STEP);

  always_comb begin
    nxt_state   = state_ff;
    nxt_elapsed = elapsed_ff;
    case (state_ff)
      ST_IDLE: begin
        if (src) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!src) begin
          nxt_state   = ST_HOLD;
          nxt_elapsed = '0;
        end
      end
      ST_HOLD: begin
        // a returning source cancels the running drop-off
        if (src) begin
          nxt_state = ST_ACTIVE;
        end else if (delay_done) begin
          nxt_state = ST_IDLE;
        end else if (ms_tick) begin
          nxt_elapsed = elapsed_ff + DELAY_STEP;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_ff   <= ST_IDLE;
      elapsed_ff <= '0;
      held_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      elapsed_ff <= nxt_elapsed;
      held_ff    <= (nxt_state != ST_IDLE);
    end
  end

  a_hold_full_delay: assert property (
    @(posedge sys_clk) disable iff (reset)
    $fell(held_ff) |-> $past(elapsed_ff) >= $past(delay_ms) - DELAY_STEP && $past(ms_tick))
    else $error("output dropped before the full drop-off delay");

  a_hold_cancel: assert property (
    @(posedge sys_clk) disable iff (reset)
    (state_ff == ST_HOLD && src) |=> (held_ff && state_ff == ST_ACTIVE) ##1 held_ff)
    else $error("returning source did not cancel the drop-off");

endmodule // dropoff_stretcher

// File: tb/far_side_model.sv
// far-side model: dead-line detector and close-command logic
`timescale 1ns/1ns
module far_side_model (
  input  wire logic dead_req,
  input  wire logic close_req,
  output logic      line_deenergized_in,
  output logic      breaker_close_cmd_in
);
  // plain logic levels, no glitch filtering modelled
  assign line_deenergized_in  = dead_req;
  assign breaker_close_cmd_in = close_req;
endmodule // far_side_model

// File: tb/test_close_fault_window_timer.sv
// self-checking bench for the close-onto-fault window timer
`timescale 1ns/1ns
module test_close_fault_window_timer;
  import cfw_pkg::*;
  localparam int T = 4;
  logic               sys_clk   = 1'b0;
  logic               reset     = 1'b1;
  logic               dead_req  = 1'b0;
  logic               close_req = 1'b0;
  logic [DELAY_W-1:0] setting   = '0;
  logic               load      = 1'b0;
  logic               line_in;
  logic               close_in;
  logic               auto_out;
  logic               man_out;
  logic [DELAY_W-1:0] delay_rb;
  int                 err_count = 0;
  int                 tests_run = 0;

  always #25 sys_clk = ~sys_clk;

  far_side_model far_side_model_i (.dead_req(dead_req), .close_req(close_req),
    .line_deenergized_in(line_in), .breaker_close_cmd_in(close_in));

  close_fault_window_timer #(.TICK_CYCLES(T)) close_fault_window_timer_i (
    .sys_clk(sys_clk), .reset(reset), .line_deenergized_in(line_in),
    .breaker_close_cmd_in(close_in), .dropoff_delay_setting(setting),
    .dropoff_delay_load(load), .auto_close_fault_window_out(auto_out),
    .manual_close_fault_window_out(man_out), .dropoff_delay_ff(delay_rb));

  task automatic chk_val(input logic [DELAY_W-1:0] got, input logic [DELAY_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    tests_run++;
    if (n < lo || n > hi) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, n, lo, hi);
    end
  endtask

  // bounded wait; the range check flags a wait that ran out
  task automatic wait_out(input bit sel_auto, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((sel_auto ? auto_out : man_out) !== lvl && n < 20000);
  endtask

  task automatic t_reset;
    chk_val(14'(auto_out), '0);
    chk_val(14'(man_out), '0);
    chk_val(delay_rb, DROPOFF_RESET_MS);
    $display("test reset done");
  endtask

  task automatic t_manual;
    int n;
    close_req = 1'b1;
    wait_out(0, 1'b1, n);
    chk_rng(n, 1, 2);
    chk_val(14'(auto_out), '0);
    close_req = 1'b0;
    wait_out(0, 1'b0, n);
    chk_rng(n, 999*T+1, 1000*T+3);
    $display("test manual done");
  endtask

  task automatic t_load;
    logic [DELAY_W-1:0] vin[4] = '{14'h3fff, 14'h0063, 14'h2711, 14'h0064};
    logic [DELAY_W-1:0] vex[4] = '{14'h2710, 14'h0064, 14'h2710, 14'h0064};
    load = 1'b1;
    for (int i = 0; i < 4; i++) begin
      setting = vin[i];
      @(negedge sys_clk);
      chk_val(delay_rb, vex[i]);
    end
    load = 1'b0;
    $display("test load done");
  endtask

  task automatic t_auto;
    int n;
    dead_req = 1'b1;
    repeat (700) @(negedge sys_clk);
    chk_val(14'(auto_out), '0);
    dead_req = 1'b0;
    @(negedge sys_clk);
    dead_req = 1'b1;
    wait_out(1, 1'b1, n);
    chk_rng(n, 199*T+2, 200*T+3);
    chk_val(14'(man_out), '0);
    dead_req = 1'b0;
    wait_out(1, 1'b0, n);
    chk_rng(n, 99*T+1, 100*T+4);
    $display("test auto done");
  endtask

  task automatic t_retrig;
    int n;
    int lows = 0;
    close_req = 1'b1;
    @(negedge sys_clk);
    close_req = 1'b0;
    wait_out(0, 1'b1, n);
    repeat (200) begin
      @(negedge sys_clk);
      if (man_out !== 1'b1) lows++;
    end
    close_req = 1'b1;
    @(negedge sys_clk);
    close_req = 1'b0;
    @(negedge sys_clk);
    if (man_out !== 1'b1) lows++;
    chk_rng(lows, 0, 0);
    wait_out(0, 1'b0, n);
    chk_rng(n, 99*T, 100*T+3);
    $display("test retrigger done");
  endtask

  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    t_reset;
    t_manual;
    t_load;
    t_auto;
    t_retrig;
    conclude;
  end

  // the tests need some 7000 cycles
  initial begin
    repeat (30000) @(negedge sys_clk);
    err_count++;
    conclude;
  end
endmodule // test_close_fault_window_timer
